// ==== host_port_model.sv ====
// Host serial port model driving the loader pins
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
  output logic cs_n = 1'b1,
  output logic fs = 1'b1,
  output logic sclk = 1'b1,
  output logic sdata = 1'b0
);
  task automatic xfer(input logic [15:0] w, input int n, input int md);
    // Mode 4 keeps the device deselected for the whole frame
    cs_n = (md == 4);
    #20.3 fs = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      #(i == 7 && md == 3 ? 300 : 31) sdata = w[i];
      #31 sclk = 1'b0;
      #62 sclk = 1'b1;
      sdata = ~w[i];
    end
    #20 cs_n = (md == 2 || md == 4);
    #20 fs = 1'b1;
    #20 cs_n = (md != 0);
  endtask : xfer
endmodule : host_port_model
`default_nettype wire

// ==== serial_dac_word_loader.sv ====
// Serial input and latch control of a 12-bit voltage-output converter
`timescale 1ns/1ps
`default_nettype none
module serial_dac_word_loader
  import word_loader_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CHIP_SELECT_N,
  input wire logic FRAME_SYNC,
  input wire logic SERIAL_CLK,
  input wire logic SERIAL_DATA,
  output logic [CODE_BITS-1:0] CODE,
  output logic SPEED_SELECT,
  output logic POWER_DOWN_SELECT,
  output logic [AMP_COUNT-1:0] AMP_DISABLE,
  output logic UPDATE
);
  // Three-stage samplers; decisions use stages two and three only
  logic [2:0] cs_sync_ff;
  logic [2:0] fs_sync_ff;
  logic [2:0] sck_sync_ff;
  logic [2:0] din_sync_ff;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      // Select and frame seeded high so release shows no edge
      cs_sync_ff <= 3'h7;
      fs_sync_ff <= 3'h7;
      sck_sync_ff <= 3'h0;
      din_sync_ff <= 3'h0;
    end else begin
      cs_sync_ff <= {cs_sync_ff[1:0], CHIP_SELECT_N};
      fs_sync_ff <= {fs_sync_ff[1:0], FRAME_SYNC};
      sck_sync_ff <= {sck_sync_ff[1:0], SERIAL_CLK};
      din_sync_ff <= {din_sync_ff[1:0], SERIAL_DATA};
    end
  end

  // Agreed levels: change accepted once stages two and three match
  logic cs_n_lvl_ff;
  logic fs_lvl_ff;
  logic sck_lvl_ff;
  logic din_lvl_ff;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cs_n_lvl_ff <= 1'b1;
      fs_lvl_ff <= 1'b1;
      sck_lvl_ff <= 1'b0;
      din_lvl_ff <= 1'b0;
    end else begin
      if (cs_sync_ff[1] == cs_sync_ff[2]) cs_n_lvl_ff <= cs_sync_ff[2];
      if (fs_sync_ff[1] == fs_sync_ff[2]) fs_lvl_ff <= fs_sync_ff[2];
      if (sck_sync_ff[1] == sck_sync_ff[2]) sck_lvl_ff <= sck_sync_ff[2];
      if (din_sync_ff[1] == din_sync_ff[2]) din_lvl_ff <= din_sync_ff[2];
    end
  end

  logic fs_fall;
  logic fs_rise;
  logic sck_fall;
  logic sck_rise;
  logic selected;

  // Edge counts once stages two and three agree on the new level
  function automatic logic agreed_edge(input logic lvl, input logic s2, input logic s3,
                                       input logic to_high);
    return (s2 == s3) && (s3 == to_high) && (lvl != to_high);
  endfunction : agreed_edge

  // Data is sampled one stage ahead of the clock edge decision
  assign fs_fall = agreed_edge(fs_lvl_ff, fs_sync_ff[1], fs_sync_ff[2], 1'b0);
  assign fs_rise = agreed_edge(fs_lvl_ff, fs_sync_ff[1], fs_sync_ff[2], 1'b1);
  assign sck_fall = agreed_edge(sck_lvl_ff, sck_sync_ff[1], sck_sync_ff[2], 1'b0);
  assign sck_rise = agreed_edge(sck_lvl_ff, sck_sync_ff[1], sck_sync_ff[2], 1'b1);
  assign selected = !cs_n_lvl_ff;

  frame_state_t state_ff;
  frame_state_t nxt_state;
  logic [WORD_BITS-1:0] shift_ff;
  logic [4:0] bit_cnt_ff;
  logic push;
  logic push_ready;

  always_comb begin
    nxt_state = state_ff;
    push = 1'b0;
    case (state_ff)
      IDLE_S: begin
        if (selected && fs_fall) nxt_state = SHIFT_S;
      end
      SHIFT_S: begin
        if (!selected) begin
          // Deselect mid-frame drops the word, nothing latched
          nxt_state = IDLE_S;
        end else if (fs_rise && bit_cnt_ff != 5'h0) begin
          push = 1'b1;
          nxt_state = IDLE_S;
        end else if (fs_rise) begin
          // Frame closed before any bit: nothing to latch
          nxt_state = IDLE_S;
        end else if (bit_cnt_ff == BIT_COUNT_FULL) begin
          nxt_state = WAIT_RISE_S;
        end
      end
      WAIT_RISE_S: begin
        if (sck_rise || fs_rise) begin
          push = 1'b1;
          nxt_state = IDLE_S;
        end else if (!selected) begin
          // Deselect after sixteen bits still latches the word
          push = 1'b1;
          nxt_state = IDLE_S;
        end
      end
      default: nxt_state = IDLE_S;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_ff <= IDLE_S;
    end else begin
      state_ff <= nxt_state;
    end
  end

  logic take_bit;

  // Bits after the sixteenth are ignored
  assign take_bit = state_ff == SHIFT_S && selected && !fs_rise && sck_fall
                    && bit_cnt_ff != BIT_COUNT_FULL;

  // shift MSB first on falling clock
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      shift_ff <= WORD_RESET;
    end else if (take_bit) begin
      shift_ff <= {shift_ff[WORD_BITS-2:0], din_lvl_ff};
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      bit_cnt_ff <= 5'h0;
    end else if (state_ff == IDLE_S) begin
      bit_cnt_ff <= 5'h0;
    end else if (take_bit) begin
      bit_cnt_ff <= bit_cnt_ff + 5'h1;
    end
  end

  // Early frame end leaves the word right-aligned as shifted so far
  logic [WORD_BITS-1:0] buf_word;
  logic buf_valid;
  logic latch_ready;

  // Buffer decouples capture from latch so no finished word is lost
  word_buffer u_buffer (
    .clk(REF_CLK),
    .rst(RST),
    .in_valid(push),
    .in_ready(push_ready),
    .in_data(shift_ff),
    .out_valid(buf_valid),
    .out_ready(latch_ready),
    .out_data(buf_word)
  );

  logic [CODE_BITS-1:0] code_ff;
  logic speed_ff;
  logic power_ff;
  logic update_ff;

  // One word per pulse keeps each update a separate one-cycle pulse
  assign latch_ready = !update_ff;

  // one-cycle pulse with each latch update
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      update_ff <= 1'b0;
    end else begin
      update_ff <= buf_valid && latch_ready;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      code_ff <= CODE_RESET;
      speed_ff <= 1'b0;
      power_ff <= 1'b0;
    end else if (buf_valid && latch_ready) begin
      code_ff <= buf_word[CODE_MSB:0];
      speed_ff <= buf_word[SPEED_POS];
      power_ff <= buf_word[POWER_POS];
    end
  end

  assign CODE = code_ff;
  assign SPEED_SELECT = speed_ff;
  assign POWER_DOWN_SELECT = power_ff;
  assign UPDATE = update_ff;

  genvar g;
  generate
    for (g = 0; g < AMP_COUNT; g++) begin : g_amp
      assign AMP_DISABLE[g] = power_ff;
    end
  endgenerate

  // Buffer never fills: the latch drains one word per pulse
  logic unused_ok;
  assign unused_ok = push_ready;
endmodule : serial_dac_word_loader
`default_nettype wire

// ==== tb_top.sv ====
// Bench for the serial word loader
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, fs, sclk, sd, speed_select, power_down_select, upd;
  logic [11:0] code;
  logic [1:0] amp;
  int n_errors = 0;
  int comparisons = 0;
  int n_upd = 0;
  int cyc = 0;
  initial begin
    forever #5 clk = ~clk;
  end
  host_port_model host_u (.cs_n(cs_n), .fs(fs), .sclk(sclk), .sdata(sd));
  serial_dac_word_loader dut_u (.REF_CLK(clk), .RST(rst), .CHIP_SELECT_N(cs_n),
    .FRAME_SYNC(fs), .SERIAL_CLK(sclk), .SERIAL_DATA(sd), .CODE(code),
    .SPEED_SELECT(speed_select), .POWER_DOWN_SELECT(power_down_select), .AMP_DISABLE(amp), .UPDATE(upd));
  task automatic final_report();
    $display("checks %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  always @(negedge clk) begin
    cyc <= cyc + 1;
    if (upd === 1'b1) n_upd <= n_upd + 1;
    // Seven frames need about 1400 cycles
    if (cyc == 5000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic frame(input logic [15:0] w, input int n, input int md,
    input logic [15:0] e, input int nu);
    int u0;
    u0 = n_upd;
    host_u.xfer(w, n, md);
    repeat (20) @(negedge clk);
    check("outs", {code, speed_select, power_down_select, amp}, {e[11:0], e[14:13], {2{e[13]}}});
    check("updates", 16'(n_upd - u0), 16'(nu));
  endtask : frame
  task automatic t_modes();
    frame(16'h4ABC, 16, 1, 16'h4ABC, 1);
    frame(16'hA123, 16, 0, 16'hA123, 1);
    frame(16'h5FFF, 16, 3, 16'h5FFF, 1);
    $display("modes done");
  endtask : t_modes
  task automatic t_partial();
    frame(16'hC300, 8, 1, 16'hFFC3, 1);
    frame(16'h1234, 5, 2, 16'hFFC3, 0);
    frame(16'h2000, 16, 1, 16'h2000, 1);
    frame(16'h0ABC, 16, 4, 16'h2000, 0);
    $display("partial done");
  endtask : t_partial
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    check("reset", {code, speed_select, power_down_select, amp}, 16'h0000);
    t_modes();
    t_partial();
    final_report();
  end
endmodule : tb_top
`default_nettype wire

// ==== word_buffer.sv ====
// Two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module word_buffer
  import word_loader_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WORD_BITS-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WORD_BITS-1:0] out_data
);
  logic [WORD_BITS-1:0] mem_ff [BUF_DEPTH];
  logic wr_ptr_ff;
  logic rd_ptr_ff;
  logic [1:0] count_ff;
  logic push;
  logic pop;

  assign in_ready = (count_ff != 2'h2);
  assign out_valid = (count_ff != 2'h0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[rd_ptr_ff];

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_ff[0] <= WORD_RESET;
      mem_ff[1] <= WORD_RESET;
    end else if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff <= 2'h0;
    end else begin
      if (push) wr_ptr_ff <= ~wr_ptr_ff;
      if (pop) rd_ptr_ff <= ~rd_ptr_ff;
      count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : word_buffer
`default_nettype wire

// ==== word_loader_checker.sv ====
// Port assertions for the serial word loader
`timescale 1ns/1ps
`default_nettype none
module word_loader_checker (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CHIP_SELECT_N,
  input wire logic FRAME_SYNC,
  input wire logic SERIAL_CLK,
  input wire logic SERIAL_DATA,
  input wire logic [11:0] CODE,
  input wire logic SPEED_SELECT,
  input wire logic POWER_DOWN_SELECT,
  input wire logic [1:0] AMP_DISABLE,
  input wire logic UPDATE
);
  logic [15:0] sh_ff;
  logic [4:0] bits_ff;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Raw pins, so it runs ahead of the synchronisers
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      sh_ff <= 16'h0000;
    end else if ($fell(SERIAL_CLK) && !FRAME_SYNC && !CHIP_SELECT_N) begin
      sh_ff <= {sh_ff[14:0], SERIAL_DATA};
    end
  end
  // Falls per frame on raw pins, stopping at sixteen
  always_ff @(posedge REF_CLK) begin
    if (RST || FRAME_SYNC) begin
      bits_ff <= 5'h00;
    end else if ($fell(SERIAL_CLK) && !CHIP_SELECT_N && bits_ff != 5'h10) begin
      bits_ff <= bits_ff + 5'h01;
    end
  end
  property p_clr; disable iff (1'b0) RST |=> !UPDATE && CODE == 12'h000; endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_cs; CHIP_SELECT_N [*8] |-> ##4 !UPDATE; endproperty
  a_cs: assert property (p_cs) else $error("cs");
  property p_one; UPDATE |=> !UPDATE; endproperty
  a_one: assert property (p_one) else $error("one");
  property p_code; UPDATE |-> CODE == sh_ff[11:0]; endproperty
  a_code: assert property (p_code) else $error("code");
  property p_spd; UPDATE |-> SPEED_SELECT == sh_ff[14]; endproperty
  a_spd: assert property (p_spd) else $error("spd");
  property p_pwr; UPDATE |-> POWER_DOWN_SELECT == sh_ff[13]; endproperty
  a_pwr: assert property (p_pwr) else $error("pwr");
  property p_amp; AMP_DISABLE == {2{POWER_DOWN_SELECT}}; endproperty
  a_amp: assert property (p_amp) else $error("amp");
  property p_hold; !UPDATE |-> $stable({CODE, SPEED_SELECT, POWER_DOWN_SELECT}); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_rise;
    $rose(SERIAL_CLK) && bits_ff == 5'h10 && !CHIP_SELECT_N |-> ##[3:8] UPDATE;
  endproperty
  a_rise: assert property (p_rise) else $error("rise");
  property p_early;
    $rose(FRAME_SYNC) && bits_ff != 5'h00 && bits_ff != 5'h10 && !CHIP_SELECT_N
      |-> ##[3:8] UPDATE;
  endproperty
  a_early: assert property (p_early) else $error("early");
endmodule : word_loader_checker
bind serial_dac_word_loader word_loader_checker chk_u (.REF_CLK, .RST, .CHIP_SELECT_N,
  .FRAME_SYNC, .SERIAL_CLK, .SERIAL_DATA, .CODE, .SPEED_SELECT, .POWER_DOWN_SELECT,
  .AMP_DISABLE, .UPDATE);
`default_nettype wire

// ==== word_loader_pkg.sv ====
// Constants and types for the serial converter word loader
// Functional notes
// - Reset clears shift register and output latch
// - Frame sync fall starts, MSB first
// - Latch after sixteen bits or early rise
// - Four-wire and three-wire chip select modes
// - Latch on rising clock after sixteenth fall
// - Word is four control, twelve code
// - Code bits eleven to zero loaded
// - Bit fourteen selects fast speed
// - Bit thirteen selects power down
// - Power down disables all amplifiers
package word_loader_pkg;
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 12;
  localparam int SPEED_POS = 14;
  localparam int POWER_POS = 13;
  localparam int CODE_MSB = 11;
  localparam logic [4:0] BIT_COUNT_FULL = 5'h10;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [11:0] CODE_RESET = 12'h000;
  localparam int AMP_COUNT = 2;
  localparam int BUF_DEPTH = 2;
  typedef enum logic [1:0] {IDLE_S, SHIFT_S, WAIT_RISE_S} frame_state_t;
endpackage : word_loader_pkg
